/* design/sdpi_top.sv */
// Stall detection with inrush blanking and PI integral gain register
// ==========================================================
// Notes on behaviour
// - Integral gain register at 0x19 resets to 0x21: multiplier 1, divisor code 001b.
// - Divisor code bits 7..5: 32,64,128,256,512,16,1 for codes 000b..110b.
// - Bits 4..0 hold the five-bit read/write integral multiplier.
// - Applied integral gain is multiplier divided by selected divisor.
// - Stall compares sensed current level against reference, or fixed 3 V level.
// - During programmed inrush blanking after start, high current is not a stall.
// - Stall response select pin chooses the action taken on a stall.
// - Current regulation select pin enables regulation during inrush and stall.
// - On stall, fault_n goes low and host-readable status bit 0 gets set.
// - One trip threshold from the reference serves stall and regulation.
`include "sdpi_cfg.svh"
module sdpi_top
   import sdpi_pkg::*;
#(
   parameter int BLANK_STEP_CYC = `SDPI_BLANK_STEP_CYC,
   parameter logic [6:0] DEV_ADDR = `SDPI_I2C_ADDR,
   parameter logic [7:0] FIXED_REF = `SDPI_FIXED_REF
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic stall_response_sel_in,
   input wire logic current_reg_sel_in,
   input wire logic motor_run_in,
   input wire logic [7:0] current_sense_out_lvl_in,
   input wire logic [7:0] trip_current_level_in,
   output logic fault_n_out,
   output logic fault_n_oe_out,
   output logic bridge_en_out,
   output logic chop_out,
   output logic [4:0] integral_multiplier_out,
   output logic [3:0] integral_shift_out
);
   // ==========================================================
   // Register access over I2C
   sdpi_wr_t wr;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   logic sda_oe_i;
   sdpi_i2c_target #(.DEV_ADDR(DEV_ADDR)) u_i2c (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_oe_out(sda_oe_i),
      .wr_out(wr),
      .rd_addr_out(rd_addr),
      .rd_data_in(rd_data)
   );
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sda_out <= 1'b0;
         sda_oe_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         sda_oe_out <= sda_oe_i;
      end
   end

   logic [7:0] pi_integral_gain_ff;
   logic [7:0] inrush_blank_time_ff;
   logic stall_flag_ff;
   logic blanking;
   wire wr_gain = wr.wr && (wr.addr == `SDPI_REG_GAIN);
   wire wr_blank = wr.wr && (wr.addr == `SDPI_REG_BLANK);
   wire clr_stall = wr.wr && (wr.addr == `SDPI_REG_STAT) && wr.data[`SDPI_STAT_STALL];
   wire [7:0] stat_w = {6'h00, blanking, stall_flag_ff};
   assign rd_data = (rd_addr == `SDPI_REG_GAIN) ? pi_integral_gain_ff :
                    (rd_addr == `SDPI_REG_BLANK) ? inrush_blank_time_ff :
                    (rd_addr == `SDPI_REG_STAT) ? stat_w : 8'h00;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pi_integral_gain_ff <= `SDPI_GAIN_RST;
         inrush_blank_time_ff <= `SDPI_BLANK_RST;
      end else begin
         if (wr_gain) pi_integral_gain_ff <= wr.data;
         if (wr_blank) inrush_blank_time_ff <= wr.data;
      end
   end

   // ==========================================================
   // Integral gain: divisors are powers of two, so the loop shifts
   wire [2:0] div_sel = pi_integral_gain_ff[`SDPI_DIV_MSB:`SDPI_DIV_LSB];
   logic [3:0] nxt_shift;
   always_comb begin
      case (div_sel)
         3'h0: nxt_shift = 4'h5;
         3'h1: nxt_shift = 4'h6;
         3'h2: nxt_shift = 4'h7;
         3'h3: nxt_shift = 4'h8;
         3'h4: nxt_shift = 4'h9;
         3'h5: nxt_shift = 4'h4;
         3'h6: nxt_shift = 4'h0;
         default: nxt_shift = 4'h5;
      endcase
   end
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         integral_multiplier_out <= 5'h01;
         integral_shift_out <= 4'h6;
      end else begin
         integral_multiplier_out <= pi_integral_gain_ff[`SDPI_MULT_MSB:`SDPI_MULT_LSB];
         integral_shift_out <= nxt_shift;
      end
   end

   // ==========================================================
   // Mode pins come from the board, so they are synchronised
   logic [1:0] resp_sel_sync_ff, reg_sel_sync_ff;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         resp_sel_sync_ff <= 2'b00;
         reg_sel_sync_ff <= 2'b00;
      end else begin
         resp_sel_sync_ff <= {resp_sel_sync_ff[0], stall_response_sel_in};
         reg_sel_sync_ff <= {reg_sel_sync_ff[0], current_reg_sel_in};
      end
   end
   wire resp_sel = resp_sel_sync_ff[1];
   wire reg_sel = reg_sel_sync_ff[1];

   // ==========================================================
   // Trip threshold, clamped at the fixed 3 V equivalent
   wire [7:0] trip_lvl = (trip_current_level_in > FIXED_REF) ? FIXED_REF
                                                             : trip_current_level_in;
   wire over_trip = current_sense_out_lvl_in > trip_lvl;

   // ==========================================================
   // Inrush blanking: a step divider and a count loaded at start
   logic run_d_ff;
   logic [31:0] step_cnt_ff;
   logic [7:0] blank_cnt_ff;
   wire run_start = motor_run_in & ~run_d_ff;
   wire step_w = (step_cnt_ff == 32'(BLANK_STEP_CYC - 1));
   assign blanking = run_start || (blank_cnt_ff != 8'h00);
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         run_d_ff <= 1'b0;
         step_cnt_ff <= 32'h0000_0000;
         blank_cnt_ff <= 8'h00;
      end else begin
         run_d_ff <= motor_run_in;
         step_cnt_ff <= (run_start || step_w) ? 32'h0000_0000 : step_cnt_ff + 32'h0000_0001;
         if (run_start) blank_cnt_ff <= inrush_blank_time_ff;
         else if (step_w && blank_cnt_ff != 8'h00) blank_cnt_ff <= blank_cnt_ff - 8'h01;
      end
   end

   // ==========================================================
   // Stall flag, response and regulation
   wire stall_evt = motor_run_in & ~blanking & over_trip;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         stall_flag_ff <= 1'b0;
         fault_n_out <= 1'b0;
         fault_n_oe_out <= 1'b0;
         bridge_en_out <= 1'b0;
         chop_out <= 1'b0;
      end else begin
         // Set wins over a clear arriving in the same cycle
         if (stall_evt) stall_flag_ff <= 1'b1;
         else if (clr_stall) stall_flag_ff <= 1'b0;
         fault_n_out <= 1'b0;
         fault_n_oe_out <= stall_flag_ff;
         // Low select stops the bridge until software clears the flag
         bridge_en_out <= motor_run_in & ~(stall_flag_ff & ~resp_sel);
         chop_out <= reg_sel & motor_run_in & over_trip;
      end
   end

   // ==========================================================
   // Checks
   sequence start_s;
      $rose(motor_run_in) && inrush_blank_time_ff != 8'h00;
   endsequence
   sequence stall_report_s;
      stall_flag_ff ##1 fault_n_oe_out;
   endsequence
   gain_reset_val_a: assert property (@(posedge clk_in) $rose(nrst_in) |->
      pi_integral_gain_ff == `SDPI_GAIN_RST) else $error("gain reset value wrong");
   div_decode_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      div_sel == 3'h5 |=> integral_shift_out == 4'h4) else $error("divisor 16 wrong");
   div_one_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      div_sel == 3'h6 |=> integral_shift_out == 4'h0) else $error("divisor 1 wrong");
   mult_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      wr_gain |=> ##1 integral_multiplier_out == $past(wr.data[4:0], 2))
      else $error("multiplier not applied");
   blank_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      start_s |=> blanking [*2]) else $error("blanking not started");
   blank_load_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      run_start |=> blank_cnt_ff == $past(inrush_blank_time_ff))
      else $error("blank time not loaded");
   no_blank_stall_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      blanking && !stall_flag_ff |=> !stall_flag_ff) else $error("stall during blanking");
   stall_set_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      motor_run_in && !blanking && over_trip |=> stall_report_s)
      else $error("stall not flagged");
   set_wins_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      stall_evt && clr_stall |=> stall_flag_ff) else $error("clear beat stall set");
   flag_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      clr_stall && !stall_evt |=> !stall_flag_ff) else $error("stall flag not cleared");
   flag_sticky_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      stall_flag_ff && !clr_stall |=> stall_flag_ff) else $error("stall flag dropped");
   trip_clamp_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      over_trip |-> current_sense_out_lvl_in > FIXED_REF ||
      current_sense_out_lvl_in > trip_current_level_in) else $error("trip compare wrong");
   fixed_ref_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      trip_current_level_in >= FIXED_REF && current_sense_out_lvl_in <= FIXED_REF |->
      !over_trip) else $error("fixed trip level ignored");
   stall_stop_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      stall_flag_ff && !resp_sel |=> !bridge_en_out) else $error("bridge not stopped");
   report_only_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      resp_sel && motor_run_in |=> bridge_en_out) else $error("bridge stopped in report mode");
   reg_mode_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      chop_out |-> $past(reg_sel) && $past(over_trip)) else $error("regulation mode wrong");
   reg_off_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !reg_sel |=> !chop_out) else $error("chop without regulation mode");
endmodule // sdpi_top

/* design/sdpi_cfg.svh */
// Register map, field positions, reset values and timing counts
`ifndef SDPI_CFG_SVH
`define SDPI_CFG_SVH
`define SDPI_REG_GAIN 8'h19
`define SDPI_REG_BLANK 8'h1A
`define SDPI_REG_STAT 8'h1B
`define SDPI_GAIN_RST 8'h21
`define SDPI_BLANK_RST 8'h0A
`define SDPI_DIV_MSB 7
`define SDPI_DIV_LSB 5
`define SDPI_MULT_MSB 4
`define SDPI_MULT_LSB 0
`define SDPI_STAT_STALL 0
`define SDPI_STAT_BLANK 1
`define SDPI_CLK_NS 20
`define SDPI_BLANK_STEP_NS 100000
`define SDPI_BLANK_STEP_CYC (`SDPI_BLANK_STEP_NS / `SDPI_CLK_NS)
`define SDPI_I2C_ADDR 7'h30
`define SDPI_FIXED_REF 8'hC0
`endif

/* design/sdpi_pkg.sv */
// Types shared by the stall detect and integral gain block
package sdpi_pkg;
   typedef enum logic [2:0] {
      SDPI_IDLE, SDPI_ADDR, SDPI_PTR, SDPI_WDATA, SDPI_ACK, SDPI_RDATA, SDPI_RACK
   } sdpi_i2c_st_t;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } sdpi_wr_t;
endpackage : sdpi_pkg

/* design/sdpi_i2c_target.sv */
// I2C target that turns bus transfers into register writes and reads
`include "sdpi_cfg.svh"
module sdpi_i2c_target
   import sdpi_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = `SDPI_I2C_ADDR
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_oe_out,
   output sdpi_wr_t wr_out,
   output logic [7:0] rd_addr_out,
   input wire logic [7:0] rd_data_in
);
   // ==========================================================
   // Pin synchronisers
   logic [1:0] scl_sync_ff, sda_sync_ff;
   logic scl_d_ff, sda_d_ff;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         scl_sync_ff <= 2'b11;
         sda_sync_ff <= 2'b11;
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_sync_ff <= {scl_sync_ff[0], scl_in};
         sda_sync_ff <= {sda_sync_ff[0], sda_in};
         scl_d_ff <= scl_sync_ff[1];
         sda_d_ff <= sda_sync_ff[1];
      end
   end
   wire scl_s = scl_sync_ff[1];
   wire sda_s = sda_sync_ff[1];
   wire start_w = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
   wire stop_w = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
   wire rise_w = scl_s & ~scl_d_ff;
   wire fall_w = ~scl_s & scl_d_ff;

   // ==========================================================
   // Protocol engine
   sdpi_i2c_st_t st_ff;
   logic [7:0] sh_ff, tx_ff, ptr_ff;
   logic [3:0] cnt_ff;
   logic rd_ff, ptr_ok_ff;
   wire byte_done = (cnt_ff == 4'h8);
   wire addr_hit = (sh_ff[7:1] == DEV_ADDR);
   assign rd_addr_out = ptr_ff;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_ff <= SDPI_IDLE;
         sh_ff <= 8'h00;
         tx_ff <= 8'h00;
         ptr_ff <= 8'h00;
         cnt_ff <= 4'h0;
         rd_ff <= 1'b0;
         ptr_ok_ff <= 1'b0;
         sda_oe_out <= 1'b0;
         wr_out <= '0;
      end else begin
         wr_out.wr <= 1'b0;
         if (start_w) begin
            st_ff <= SDPI_ADDR;
            cnt_ff <= 4'h0;
            ptr_ok_ff <= 1'b0;
            sda_oe_out <= 1'b0;
         end else if (stop_w) begin
            st_ff <= SDPI_IDLE;
            sda_oe_out <= 1'b0;
         end else begin
            case (st_ff)
               SDPI_ADDR, SDPI_PTR, SDPI_WDATA: begin
                  if (rise_w && !byte_done) begin
                     sh_ff <= {sh_ff[6:0], sda_s};
                     cnt_ff <= cnt_ff + 4'h1;
                  end else if (fall_w && byte_done) begin
                     cnt_ff <= 4'h0;
                     sda_oe_out <= 1'b1;
                     st_ff <= SDPI_ACK;
                     if (st_ff == SDPI_ADDR) begin
                        rd_ff <= sh_ff[0];
                        if (!addr_hit) begin
                           sda_oe_out <= 1'b0;
                           st_ff <= SDPI_IDLE;
                        end
                     end else if (st_ff == SDPI_PTR) begin
                        ptr_ff <= sh_ff;
                        ptr_ok_ff <= 1'b1;
                     end else begin
                        wr_out <= '{wr: 1'b1, addr: ptr_ff, data: sh_ff};
                        ptr_ff <= ptr_ff + 8'h01;
                     end
                  end
               end
               SDPI_ACK: begin
                  if (fall_w) begin
                     if (rd_ff) begin
                        tx_ff <= {rd_data_in[6:0], 1'b0};
                        sda_oe_out <= ~rd_data_in[7];
                        st_ff <= SDPI_RDATA;
                     end else begin
                        sda_oe_out <= 1'b0;
                        st_ff <= ptr_ok_ff ? SDPI_WDATA : SDPI_PTR;
                     end
                  end
               end
               SDPI_RDATA: begin
                  if (rise_w) begin
                     cnt_ff <= cnt_ff + 4'h1;
                  end else if (fall_w) begin
                     if (cnt_ff == 4'h8) begin
                        sda_oe_out <= 1'b0;
                        cnt_ff <= 4'h0;
                        ptr_ff <= ptr_ff + 8'h01;
                        st_ff <= SDPI_RACK;
                     end else begin
                        sda_oe_out <= ~tx_ff[7];
                        tx_ff <= {tx_ff[6:0], 1'b0};
                     end
                  end
               end
               SDPI_RACK: begin
                  // A NACK from the host ends the read; wait for stop
                  if (rise_w) begin
                     st_ff <= sda_s ? SDPI_IDLE : SDPI_ACK;
                  end
               end
               default: st_ff <= SDPI_IDLE;
            endcase
         end
      end
   end
endmodule // sdpi_i2c_target

/* dv/sdpi_host_model.sv */
// Host controller model: bit-level I2C master on an open-drain data line
module sdpi_host_model (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_oe_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Bus phases
   // Eight clocks per SCL phase leaves margin over the four-clock minimum
   localparam int HALF = 8;
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   task automatic tick();
      repeat (HALF) @(negedge clk_in);
   endtask
   // Also serves as repeated start: data released while SCL is still low
   task automatic start();
      sda_oe_out = 1'b0;
      tick();
      scl_out = 1'b1;
      tick();
      sda_oe_out = 1'b1;
      tick();
      scl_out = 1'b0;
   endtask
   task automatic stop();
      sda_oe_out = 1'b1;
      tick();
      scl_out = 1'b1;
      tick();
      sda_oe_out = 1'b0;
      tick();
   endtask
   // Sample just before SCL falls, when the target's data has stood longest
   task automatic bit_io(input logic b, output logic s);
      sda_oe_out = ~b;
      tick();
      scl_out = 1'b1;
      tick();
      s = sda_in;
      scl_out = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                       output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ack_in, ack);
   endtask
endmodule // sdpi_host_model

/* dv/sdpi_tb.sv */
// Self-checking bench for the stall detect and integral gain block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic scl, host_oe, dut_oe, sda_o, sda_wire;
   logic resp_sel = 1'b0, reg_sel = 1'b0, run = 1'b0;
   logic [7:0] cur = 8'h00, trip = 8'h00, rd;
   logic fault_o, fault_oe, bridge, chop;
   logic [4:0] mult;
   logic [3:0] shift;
   int bad_count = 0;
   int checked = 0;
   logic [3:0] shift_tab [8] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h4, 4'h0, 4'h5};
   // Pull-up on the data line; either party pulling wins
   assign sda_wire = ~(host_oe | dut_oe);
   initial begin
      forever #10 clk_in = ~clk_in;
   end
   sdpi_host_model HOST (.clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl),
                         .sda_oe_out(host_oe));
   sdpi_top #(.BLANK_STEP_CYC(16)) DUT (
      .clk_in(clk_in), .nrst_in(nrst_in), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_o), .sda_oe_out(dut_oe), .stall_response_sel_in(resp_sel),
      .current_reg_sel_in(reg_sel), .motor_run_in(run), .current_sense_out_lvl_in(cur),
      .trip_current_level_in(trip), .fault_n_out(fault_o), .fault_n_oe_out(fault_oe),
      .bridge_en_out(bridge), .chop_out(chop), .integral_multiplier_out(mult),
      .integral_shift_out(shift));
   // ==========================================================
   // Access tasks
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic k;
      HOST.start();
      HOST.xfer(8'h60, 1'b1, q, k);
      HOST.xfer(a, 1'b1, q, k);
      HOST.xfer(d, 1'b1, q, k);
      HOST.stop();
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] q;
      logic k;
      HOST.start();
      HOST.xfer(8'h60, 1'b1, q, k);
      HOST.xfer(a, 1'b1, q, k);
      HOST.start();
      HOST.xfer(8'h61, 1'b1, q, k);
      HOST.xfer(8'hFF, 1'b1, d, k);
      HOST.stop();
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask
   task automatic give_verdict();
      if (bad_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   initial begin
      wait_clk(60000);
      bad_count++;
      give_verdict();
   end
   // ==========================================================
   // Tests
   initial begin
      wait_clk(10);
      nrst_in = 1'b1;
      wait_clk(5);
      reg_rd(8'h19, rd);
      check(rd, 8'h21);
      check({3'h0, mult}, 8'h01);
      check({4'h0, shift}, 8'h06);
      check({6'h00, sda_o, fault_o}, 8'h00);
      reg_rd(8'h1A, rd);
      check(rd, 8'h0A);
      // Every divisor code, including the unused one, with varied multipliers
      for (int i = 0; i < 8; i++) begin
         reg_wr(8'h19, {3'(i), 5'(i * 3 + 2)});
         reg_rd(8'h19, rd);
         check(rd, {3'(i), 5'(i * 3 + 2)});
         check({3'h0, mult}, {3'h0, 5'(i * 3 + 2)});
         check({4'h0, shift}, {4'h0, shift_tab[i]});
      end
      reg_rd(8'h40, rd);
      check(rd, 8'h00);
      // Long blanking, high current from the start, bridge stops on stall
      trip = 8'h50;
      cur = 8'h80;
      reg_sel = 1'b1;
      reg_wr(8'h1A, 8'hFF);
      reg_rd(8'h1A, rd);
      check(rd, 8'hFF);
      run = 1'b1;
      wait_clk(4);
      check({5'h00, fault_oe, chop, bridge}, 8'h03);
      reg_rd(8'h1B, rd);
      check(rd, 8'h02);
      check({7'h00, fault_oe}, 8'h00);
      wait_clk(4200);
      check({5'h00, fault_oe, chop, bridge}, 8'h06);
      reg_rd(8'h1B, rd);
      check(rd, 8'h01);
      cur = 8'h40;
      reg_wr(8'h1B, 8'h01);
      wait_clk(4);
      check({5'h00, fault_oe, chop, bridge}, 8'h01);
      // Reference above the fixed level: the fixed level sets the trip
      run = 1'b0;
      resp_sel = 1'b1;
      reg_sel = 1'b0;
      trip = 8'hFF;
      cur = 8'hB0;
      reg_wr(8'h1A, 8'h01);
      run = 1'b1;
      wait_clk(200);
      check({5'h00, fault_oe, chop, bridge}, 8'h01);
      cur = 8'hD0;
      wait_clk(4);
      check({5'h00, fault_oe, chop, bridge}, 8'h05);
      give_verdict();
   end
endmodule // testbench
